// ===== logic/pfs_regs.sv
// ------------------------------------------------------------------
// Base feature and page select registers, AXI4-Lite slave
// ------------------------------------------------------------------
module pfs_regs
  import pfs_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  // AXI4-Lite write address
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [PFS_ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  // AXI4-Lite write data
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  // AXI4-Lite write response
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  // AXI4-Lite read address
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [PFS_ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  // AXI4-Lite read data
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  // Device side
  input wire logic i_bus_reset,
  input wire logic i_beta_mode_active,
  input wire logic i_beta_link_strap_pin,
  input wire logic i_selfid_valid,
  input wire logic i_selfid_legacy,
  input wire logic [2:0] i_selfid_speed,
  input wire logic [PFS_PORT_STATUS_W-1:0] i_port_status,
  output logic o_fast_arb_active,
  output logic o_mixed_speed_active,
  output logic [1:0] o_selfid_bridge,
  output logic [2:0] o_page_select,
  output logic [3:0] o_port_select
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [3:0] aw_idx;
    logic aw_in_range;
    logic [7:0] wdata;
    logic wlane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [7:0] rdata;
    logic [1:0] rresp;
    logic fast_arb;
    logic mixed;
    logic [2:0] legacy;
    logic [1:0] bridge;
    logic [2:0] page;
    logic [3:0] port;
  } pfs_state_s;

  pfs_state_s st_reg;
  pfs_state_s st_next;
  logic [3:0] rd_idx;
  logic rd_in_range;
  logic [7:0] paged_data;
  logic wr_fire;
  logic rd_fire;
  logic [2:0] capped_speed;

  // ----------------------------------------------------------------
  // Handshakes
  // ----------------------------------------------------------------
  // One write and one read at a time; a held response blocks new ones
  assign o_awready = !st_reg.aw_got && !st_reg.bvalid;
  assign o_wready = !st_reg.w_got && !st_reg.bvalid;
  assign o_arready = !st_reg.rvalid;
  assign wr_fire = st_reg.aw_got && st_reg.w_got && !st_reg.bvalid;
  assign rd_fire = i_arvalid && o_arready;
  assign rd_idx = i_araddr[5:2];
  assign rd_in_range = (i_araddr[PFS_ADDR_W-1:6] == 2'h0);

  // Register file outputs
  assign o_bvalid = st_reg.bvalid;
  assign o_bresp = st_reg.bresp;
  assign o_rvalid = st_reg.rvalid;
  assign o_rdata = {24'h000000, st_reg.rdata};
  assign o_rresp = st_reg.rresp;

  // Enables act only outside beta mode
  assign o_fast_arb_active = st_reg.fast_arb && !i_beta_mode_active;
  assign o_mixed_speed_active = st_reg.mixed && !i_beta_mode_active;
  assign o_selfid_bridge = st_reg.bridge;
  assign o_page_select = st_reg.page;
  assign o_port_select = st_reg.port;

  // Legacy speeds above S400 are clipped before comparison
  assign capped_speed = (i_selfid_speed > PFS_SPEED_S400) ? PFS_SPEED_S400 : i_selfid_speed;

  // ----------------------------------------------------------------
  // Paged window
  // ----------------------------------------------------------------
  pfs_port_page pfs_port_page_inst (
    .i_page(st_reg.page),
    .i_port(st_reg.port),
    .i_reg(rd_idx[2:0]),
    .i_port_status(i_port_status),
    .o_data(paged_data)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    st_next = st_reg;
    // Address and data are taken in either order
    if (i_awvalid && o_awready)
    begin
      st_next.aw_got = 1'b1;
      st_next.aw_idx = i_awaddr[5:2];
      st_next.aw_in_range = (i_awaddr[PFS_ADDR_W-1:6] == 2'h0);
    end
    if (i_wvalid && o_wready)
    begin
      st_next.w_got = 1'b1;
      st_next.wdata = i_wdata[7:0];
      st_next.wlane0 = i_wstrb[0];
    end
    // Commit once both halves are in; only writable bits are stored
    if (wr_fire)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = PFS_RESP_OKAY;
      if (!st_reg.aw_in_range)
      begin
        st_next.bresp = PFS_RESP_SLVERR;
      end
      else
      begin
        case (st_reg.aw_idx)
          PFS_IDX_BRIDGE:
          begin
            if (st_reg.wlane0)
            begin
              st_next.bridge = st_reg.wdata[1:0];
            end
          end
          PFS_IDX_FEATURE:
          begin
            if (st_reg.wlane0)
            begin
              st_next.fast_arb = st_reg.wdata[PFS_FEAT_FAST_ARB];
              st_next.mixed = st_reg.wdata[PFS_FEAT_MIXED];
            end
          end
          PFS_IDX_PAGE_PORT:
          begin
            if (st_reg.wlane0)
            begin
              st_next.page = st_reg.wdata[PFS_PP_PAGE_LSB +: 3];
              st_next.port = st_reg.wdata[PFS_PP_PORT_LSB +: 4];
            end
          end
          default:
          begin
            // Paged control bits are not held here, so paged writes are dropped
            if (st_reg.aw_idx < PFS_IDX_PAGED_LO)
            begin
              st_next.bresp = PFS_RESP_SLVERR;
            end
          end
        endcase
      end
    end
    if (st_reg.bvalid && i_bready)
    begin
      st_next.bvalid = 1'b0;
    end
    // Read data is sampled into a flop at the address handshake
    if (st_reg.rvalid && i_rready)
    begin
      st_next.rvalid = 1'b0;
    end
    if (rd_fire)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = PFS_RESP_OKAY;
      st_next.rdata = 8'h00;
      if (!rd_in_range)
      begin
        st_next.rresp = PFS_RESP_SLVERR;
      end
      else if (rd_idx >= PFS_IDX_PAGED_LO)
      begin
        st_next.rdata = paged_data;
      end
      else
      begin
        case (rd_idx)
          PFS_IDX_BRIDGE:
          begin
            st_next.rdata[1:0] = st_reg.bridge;
          end
          PFS_IDX_FEATURE:
          begin
            st_next.rdata[PFS_FEAT_FAST_ARB] = st_reg.fast_arb;
            st_next.rdata[PFS_FEAT_MIXED] = st_reg.mixed;
            st_next.rdata[PFS_FEAT_LEGACY_LSB +: 3] = st_reg.legacy;
            st_next.rdata[PFS_FEAT_BETA_LINK] = i_beta_link_strap_pin;
          end
          PFS_IDX_PAGE_PORT:
          begin
            st_next.rdata[PFS_PP_PAGE_LSB +: 3] = st_reg.page;
            st_next.rdata[PFS_PP_PORT_LSB +: 4] = st_reg.port;
          end
          default:
          begin
            st_next.rresp = PFS_RESP_SLVERR;
          end
        endcase
      end
    end
    // Bus reset restarts the legacy scan; a self-ID in the same cycle still counts
    if (i_bus_reset)
    begin
      st_next.legacy = PFS_RST_LEGACY;
    end
    if (i_selfid_valid && i_selfid_legacy)
    begin
      if (i_bus_reset || (capped_speed > st_reg.legacy))
      begin
        st_next.legacy = capped_speed;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register; hardware reset only, bus reset keeps the enables
  // ----------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st_reg <= '0;
      st_reg.fast_arb <= PFS_RST_ENABLE;
      st_reg.mixed <= PFS_RST_ENABLE;
      st_reg.legacy <= PFS_RST_LEGACY;
      st_reg.bridge <= PFS_RST_BRIDGE;
      st_reg.page <= PFS_RST_PAGE;
      st_reg.port <= PFS_RST_PORT;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  fast_arb_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (wr_fire && st_reg.aw_in_range && st_reg.aw_idx == PFS_IDX_FEATURE && st_reg.wlane0)
    |=> (o_fast_arb_active == ($past(st_reg.wdata[0]) && !i_beta_mode_active)))
    else $error("fast arbitration output does not follow write");

  fast_arb_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_bus_reset && !wr_fire) |=> $stable(st_reg.fast_arb))
    else $error("fast arbitration enable changed on bus reset");

  mixed_gate_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_beta_mode_active |-> !o_mixed_speed_active)
    else $error("mixed speed concatenation active in beta mode");

  legacy_cap_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_selfid_valid && i_selfid_legacy && i_selfid_speed >= PFS_SPEED_S400)
    |=> (st_reg.legacy == PFS_SPEED_S400))
    else $error("legacy speed not capped at S400");

  beta_link_read_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (rd_fire && rd_in_range && rd_idx == PFS_IDX_FEATURE)
    |=> (o_rdata[PFS_FEAT_BETA_LINK] == $past(i_beta_link_strap_pin)))
    else $error("beta link bit does not follow strap pin");

  bridge_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (wr_fire && st_reg.aw_in_range && st_reg.aw_idx == PFS_IDX_BRIDGE && st_reg.wlane0)
    |=> (o_selfid_bridge == $past(st_reg.wdata[1:0])))
    else $error("bridge field not updated by write");

  page_write_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (wr_fire && st_reg.aw_in_range && st_reg.aw_idx == PFS_IDX_PAGE_PORT && st_reg.wlane0)
    |=> (o_page_select == $past(st_reg.wdata[7:5])))
    else $error("page select not updated by write");

  port_keep_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (i_bus_reset && !wr_fire) |=> $stable(o_port_select) && $stable(o_page_select))
    else $error("page or port select changed on bus reset");

  unimpl_zero_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (rd_fire && rd_in_range && rd_idx >= PFS_IDX_PAGED_LO && st_reg.port >= PFS_NUM_PORTS)
    |=> (o_rvalid && o_rdata == 32'h00000000))
    else $error("unimplemented port page not zero");

  ro_ignored_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (wr_fire && st_reg.aw_idx == PFS_IDX_FEATURE && !i_selfid_valid && !i_bus_reset)
    |=> $stable(st_reg.legacy))
    else $error("write changed read-only legacy speed");

  bresp_hold_a: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (o_bvalid && !i_bready) |=> (o_bvalid && $stable(o_bresp)))
    else $error("write response dropped before bready");

  feature_write_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    wr_fire && st_reg.aw_idx == PFS_IDX_FEATURE ##[1:20] rd_fire && rd_idx == PFS_IDX_FEATURE);

  paged_read_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    rd_fire && rd_idx >= PFS_IDX_PAGED_LO && st_reg.port < PFS_NUM_PORTS);

  unimpl_read_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    rd_fire && rd_idx >= PFS_IDX_PAGED_LO && st_reg.port >= PFS_NUM_PORTS);

  legacy_cap_c: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    i_selfid_valid && i_selfid_legacy && i_selfid_speed > PFS_SPEED_S400);

endmodule

// ===== logic/pfs_pkg.sv
package pfs_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam int unsigned PFS_ADDR_W = 8;
  localparam logic [3:0] PFS_IDX_BRIDGE = 4'h4;
  localparam logic [3:0] PFS_IDX_FEATURE = 4'h5;
  localparam logic [3:0] PFS_IDX_PAGE_PORT = 4'h7;
  localparam logic [3:0] PFS_IDX_PAGED_LO = 4'h8;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned PFS_FEAT_FAST_ARB = 0;
  localparam int unsigned PFS_FEAT_MIXED = 1;
  localparam int unsigned PFS_FEAT_LEGACY_LSB = 2;
  localparam int unsigned PFS_FEAT_BETA_LINK = 5;
  localparam int unsigned PFS_PP_PORT_LSB = 0;
  localparam int unsigned PFS_PP_PAGE_LSB = 5;

  // ----------------------------------------------------------------
  // Values after reset and encodings
  // ----------------------------------------------------------------
  localparam logic PFS_RST_ENABLE = 1'b0;
  localparam logic [1:0] PFS_RST_BRIDGE = 2'h0;
  localparam logic [2:0] PFS_RST_PAGE = 3'h0;
  localparam logic [3:0] PFS_RST_PORT = 4'h0;
  localparam logic [2:0] PFS_RST_LEGACY = 3'h0;
  localparam logic [2:0] PFS_SPEED_S400 = 3'h2;
  localparam logic [2:0] PFS_PAGE_PORT_STATUS = 3'h0;
  localparam logic [3:0] PFS_NUM_PORTS = 4'h3;
  localparam int unsigned PFS_PORT_REGS = 8;
  localparam int unsigned PFS_PORT_STATUS_W = 3 * PFS_PORT_REGS * 8;
  localparam logic [1:0] PFS_RESP_OKAY = 2'h0;
  localparam logic [1:0] PFS_RESP_SLVERR = 2'h2;

endpackage

// ===== logic/pfs_port_page.sv
// ------------------------------------------------------------------
// Paged read mux for addresses 8 to 15
// ------------------------------------------------------------------
module pfs_port_page
  import pfs_pkg::*;
(
  input wire logic [2:0] i_page,
  input wire logic [3:0] i_port,
  input wire logic [2:0] i_reg,
  input wire logic [PFS_PORT_STATUS_W-1:0] i_port_status,
  output logic [7:0] o_data
);

  // Only the port status page lives here; other pages read as zero
  always_comb
  begin
    o_data = 8'h00;
    if ((i_page == PFS_PAGE_PORT_STATUS) && (i_port < PFS_NUM_PORTS))
    begin
      o_data = i_port_status[({i_port[1:0], i_reg} * 8) +: 8];
    end
    // Unimplemented port falls through to zero
  end

endmodule

// ===== tb/pfs_link_model.sv
// ------------------------------------------------------------------
// Link-layer controller model, AXI4-Lite master side
// ------------------------------------------------------------------
module pfs_link_model
  import pfs_pkg::*;
(
  input wire logic i_ref_clk,
  output logic o_awvalid,
  input wire logic i_awready,
  output logic [PFS_ADDR_W-1:0] o_awaddr,
  output logic o_wvalid,
  input wire logic i_wready,
  output logic [31:0] o_wdata,
  output logic [3:0] o_wstrb,
  input wire logic i_bvalid,
  output logic o_bready,
  output logic o_arvalid,
  input wire logic i_arready,
  output logic [PFS_ADDR_W-1:0] o_araddr,
  output logic o_rready,
  input wire logic i_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  // Bus idle from time zero
  initial
  begin
    o_awvalid = 1'b0;
    o_wvalid = 1'b0;
    o_bready = 1'b0;
    o_arvalid = 1'b0;
    o_rready = 1'b0;
    o_awaddr = '0;
    o_araddr = '0;
    o_wdata = '0;
    o_wstrb = 4'h0;
  end

  // One write; a leading edge keeps the strobes from being set twice in one step
  task automatic write(input logic [PFS_ADDR_W-1:0] a, input logic [31:0] d,
    input logic [3:0] s);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    @(posedge i_ref_clk);
    o_awvalid <= 1'b1;
    o_awaddr <= a;
    o_wvalid <= 1'b1;
    o_wdata <= d;
    o_wstrb <= s;
    while (!(aw_done && w_done))
    begin
      @(posedge i_ref_clk);
      aw_done |= i_awready;
      w_done |= i_wready;
      // Released channels show the inverse, so a late sample would be caught
      if (aw_done)
      begin
        o_awvalid <= 1'b0;
        o_awaddr <= ~a;
      end
      if (w_done)
      begin
        o_wvalid <= 1'b0;
        o_wdata <= ~d;
      end
    end
    // Ready comes after the response, so the response must stand while it waits
    do @(posedge i_ref_clk); while (!i_bvalid);
    o_bready <= 1'b1;
    @(posedge i_ref_clk);
    o_bready <= 1'b0;
  endtask

  // One read; rready held until rvalid is seen
  task automatic read(input logic [PFS_ADDR_W-1:0] a);
    @(posedge i_ref_clk);
    o_arvalid <= 1'b1;
    o_araddr <= a;
    o_rready <= 1'b1;
    do @(posedge i_ref_clk); while (!i_arready);
    o_arvalid <= 1'b0;
    o_araddr <= ~a;
    do @(posedge i_ref_clk); while (!i_rvalid);
    o_rready <= 1'b0;
  endtask
endmodule

// ===== tb/test_phy_feature_page_select_regs.sv
`define PFS_CHK(what, exp, got) \
  begin checked++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end

module test_phy_feature_page_select_regs
  import pfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rnd = 32'h28f316e2;
  logic [3:0] wstrb, port_sel;
  logic [1:0] bresp, rresp, bridge;
  logic bus_reset = 1'b0, beta_mode = 1'b0, strap = 1'b0;
  logic sid_valid = 1'b0, sid_legacy = 1'b0, fast_act, mixed_act;
  logic [2:0] sid_speed = 3'h0, page_sel, exp_leg;
  logic [PFS_PORT_STATUS_W-1:0] port_status = '0;
  logic [33:0] exp_q[$];
  logic [33:0] note;
  int fail_count = 0;
  int checked = 0;

  // ----------------------------------------------------------------
  // Clock, design and link model
  // ----------------------------------------------------------------
  always #5 ref_clk = ~ref_clk;

  pfs_regs pfs_regs_inst (.i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_awvalid(awvalid),
    .o_awready(awready), .i_awaddr(awaddr), .i_awprot(3'h0), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(wstrb), .o_bvalid(bvalid),
    .i_bready(bready), .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready),
    .i_araddr(araddr), .i_arprot(3'h0), .o_rvalid(rvalid), .i_rready(rready),
    .o_rdata(rdata), .o_rresp(rresp), .i_bus_reset(bus_reset),
    .i_beta_mode_active(beta_mode), .i_beta_link_strap_pin(strap),
    .i_selfid_valid(sid_valid), .i_selfid_legacy(sid_legacy), .i_selfid_speed(sid_speed),
    .i_port_status(port_status), .o_fast_arb_active(fast_act),
    .o_mixed_speed_active(mixed_act), .o_selfid_bridge(bridge),
    .o_page_select(page_sel), .o_port_select(port_sel));

  pfs_link_model pfs_link_model_inst (.i_ref_clk(ref_clk), .o_awvalid(awvalid),
    .i_awready(awready), .o_awaddr(awaddr), .o_wvalid(wvalid), .i_wready(wready),
    .o_wdata(wdata), .o_wstrb(wstrb), .i_bvalid(bvalid), .o_bready(bready),
    .o_arvalid(arvalid), .i_arready(arready), .o_araddr(araddr), .o_rready(rready),
    .i_rvalid(rvalid));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r,
    input logic [3:0] s = 4'hf);
    exp_q.push_back({r, 32'h0});
    pfs_link_model_inst.write(a, d, s);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    pfs_link_model_inst.read(a);
  endtask

  // One-cycle bus reset pulse, then let outputs settle
  task automatic pulse_bus_reset();
    @(posedge ref_clk);
    bus_reset <= 1'b1;
    @(posedge ref_clk);
    bus_reset <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  task automatic give_verdict();
    // A response that never came leaves its note behind
    if (exp_q.size() != 0)
      fail_count++;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Each handed-over response is matched to the oldest note
  always @(posedge ref_clk)
  begin
    if ((bvalid && bready) || (rvalid && rready))
    begin
      note = exp_q.pop_front();
      if (bvalid && bready) `PFS_CHK("write response", note, {bresp, 32'h0})
      else `PFS_CHK("read data", note, {rresp, rdata})
    end
  end

  // Hang guard; the whole run needs well under this many cycles
  initial
  begin
    repeat (8000) @(posedge ref_clk);
    fail_count++;
    give_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(8'h10, 32'h0, PFS_RESP_OKAY);
    rd(8'h14, 32'h0, PFS_RESP_OKAY);
    rd(8'h1c, 32'h0, PFS_RESP_OKAY);
    $display("test reset values done");
    // Attached link is taken to support the enhancements
    wr(8'h14, 32'hff, PFS_RESP_OKAY);
    #1;
    `PFS_CHK("fast arb", 1'b1, fast_act)
    `PFS_CHK("mixed speed", 1'b1, mixed_act)
    rd(8'h14, 32'h3, PFS_RESP_OKAY);
    @(posedge ref_clk);
    beta_mode <= 1'b1;
    pulse_bus_reset();
    `PFS_CHK("fast arb beta", 1'b0, fast_act)
    `PFS_CHK("mixed speed beta", 1'b0, mixed_act)
    @(posedge ref_clk);
    beta_mode <= 1'b0;
    strap <= 1'b1;
    @(posedge ref_clk);
    #1;
    `PFS_CHK("fast arb kept", 1'b1, fast_act)
    `PFS_CHK("mixed speed kept", 1'b1, mixed_act)
    rd(8'h14, 32'h23, PFS_RESP_OKAY);
    $display("test feature enables done");
    // Random self-ID stream; expected top speed is capped at S400
    exp_leg = 3'h0;
    for (int i = 0; i < 8; i++)
    begin
      rnd = lfsr_next(rnd);
      @(posedge ref_clk);
      sid_valid <= 1'b1;
      sid_legacy <= rnd[3];
      sid_speed <= rnd[2:0];
      if (rnd[3]) exp_leg = (rnd[2:0] > PFS_SPEED_S400) ? PFS_SPEED_S400 :
        ((rnd[2:0] > exp_leg) ? rnd[2:0] : exp_leg);
      @(posedge ref_clk);
      sid_valid <= 1'b0;
    end
    rd(8'h14, {26'h0, 1'b1, exp_leg, 2'h3}, PFS_RESP_OKAY);
    wr(8'h14, 32'h3f, PFS_RESP_OKAY);
    rd(8'h14, {26'h0, 1'b1, exp_leg, 2'h3}, PFS_RESP_OKAY);
    pulse_bus_reset();
    rd(8'h14, 32'h23, PFS_RESP_OKAY);
    wr(8'h10, 32'h3, PFS_RESP_OKAY);
    #1;
    `PFS_CHK("bridge", 2'h3, bridge)
    rd(8'h10, 32'h3, PFS_RESP_OKAY);
    // A write with no byte lane enabled must leave the bridge field alone
    wr(8'h10, 32'h0, PFS_RESP_OKAY, 4'h0);
    rd(8'h10, 32'h3, PFS_RESP_OKAY);
    $display("test legacy speed and bridge done");
    @(posedge ref_clk);
    for (int i = 0; i < 6; i++)
    begin
      rnd = lfsr_next(rnd);
      port_status[i*32 +: 32] <= rnd;
    end
    for (int p = 0; p < 5; p++)
    begin
      wr(8'h1c, p, PFS_RESP_OKAY);
      #1;
      `PFS_CHK("port select", p[3:0], port_sel)
      `PFS_CHK("page select", PFS_PAGE_PORT_STATUS, page_sel)
      for (int r = 0; r < 8; r++)
        rd(8'h20 + 8'(4 * r), (p < 3) ? {24'h0, port_status[(p*8+r)*8 +: 8]} : 32'h0,
          PFS_RESP_OKAY);
    end
    wr(8'h1c, 32'h21, PFS_RESP_OKAY);
    rd(8'h24, 32'h0, PFS_RESP_OKAY);
    pulse_bus_reset();
    `PFS_CHK("page kept", 3'h1, page_sel)
    `PFS_CHK("port kept", 4'h1, port_sel)
    rd(8'h1c, 32'h21, PFS_RESP_OKAY);
    $display("test page and port select done");
    rd(8'h00, 32'h0, PFS_RESP_SLVERR);
    wr(8'h18, 32'h5, PFS_RESP_SLVERR);
    rd(8'h40, 32'h0, PFS_RESP_SLVERR);
    wr(8'h20, 32'hff, PFS_RESP_OKAY);
    $display("test unmapped addresses done");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    #1;
    `PFS_CHK("bridge reset", 2'h0, bridge)
    `PFS_CHK("fast arb reset", 1'b0, fast_act)
    `PFS_CHK("page reset", 3'h0, page_sel)
    `PFS_CHK("port reset", 4'h0, port_sel)
    $display("test second reset done");
    give_verdict();
  end
endmodule
